// ==== src/port_ctl_pkg.sv ====
// package for the root port power, reset and overcurrent block
// assumes a single 25 MHz controller clock and a plain strobe register port
`default_nettype none
package port_ctl_pkg;
  // clock and timing
  localparam int CLOCK_HZ = 25_000_000;
  localparam int RESET_TIME_US = 10_000;  // port reset signalling length, microseconds
  localparam int RESET_CYCLES_DEFAULT = RESET_TIME_US * (CLOCK_HZ / 1_000_000);
  localparam int CNT_W = 24;              // wide enough for the default reset length
  localparam int SYNC_W = 3;              // pin synchroniser depth

  // register port widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_PORT_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_HUB_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_HUB_CMD = 4'h8;

  // port status fields
  localparam int BIT_PRESENT = 0;
  localparam int BIT_ACTIVE = 1;
  localparam int BIT_SLEEP = 2;
  localparam int BIT_OVERCURRENT = 3;
  localparam int BIT_RESET = 4;
  localparam int BIT_POWER = 8;
  localparam int BIT_POWER_OFF = 9;
  localparam int BIT_ATTACH_CHG = 16;
  localparam int BIT_RESET_CHG = 20;

  // hub control fields
  localparam int BIT_SCHEME = 0;
  localparam int BIT_NO_SWITCH = 1;
  localparam int BIT_PER_PORT_OC = 2;
  localparam int BIT_PORT_SELECT = 3;

  // hub command fields (write only)
  localparam int BIT_ALL_OFF = 0;
  localparam int BIT_ALL_ON = 16;

  // reset values
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // port reset sequencer
  typedef enum logic {RST_IDLE, RST_DRIVING} reset_phase_t;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // whole state of the port block
  typedef struct packed {
    logic power_flag;
    logic present_flag;
    logic active_flag;
    logic sleep_flag;
    logic attach_chg;
    logic reset_chg;
    logic power_switch_scheme;
    logic no_switch;
    logic per_port_oc;
    logic per_port_power_select;
    logic [SYNC_W-1:0] oc_sync;
    logic oc_level;
    logic [SYNC_W-1:0] att_sync;
    logic att_level;
    reset_phase_t phase;
    logic [CNT_W-1:0] count;
    logic [DATA_W-1:0] rdata;
  } state_t;
endpackage
`default_nettype wire

// ==== src/root_port_ctl.sv ====
// root hub downstream port: power switching, port reset, overcurrent status
// assumes the attach and overcurrent pins are asynchronous and the register
// master follows the one-cycle strobe convention with read data a cycle later
//
// Notes on behaviour
// [RL1] overcurrent clears the power flag always
// [RL2] single or global off clears power
// [RL3] global scheme: only global commands act
// [RL4] per-port selected: only single commands act
// [RL5] per-port unselected: only global commands act
// [RL6] power off clears present, active, sleep, reset
// [RL7] power flag reads 0 off, 1 on
// [RL8] writing 1 sets power, 0 ignored
// [RL9] no switching: power flag reads 1
// [RL10] reset request drives reset while flag set
// [RL11] reset end clears flag, sets change
// [RL12] reset of absent port sets attach change
// [RL13] reset request on 1, 0 ignored
// [RL14] overcurrent bit valid only per-port reporting
// [RL15] no per-port reporting: overcurrent reads 0
// [RL16] per-port reporting: bit tracks overcurrent input
// [RL17] single power-off on 1 at bit 9
// [RL18] overcurrent pin synchronised before use
// [RL19] bits 7 to 5 read zero
`default_nettype none
module root_port_ctl
  import port_ctl_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = RESET_CYCLES_DEFAULT  // reset signalling length in clocks
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire bus_req_t bus_req,
  output logic [DATA_W-1:0] rdata,
  input wire logic overcurrent_pin,
  input wire logic attach_pin,
  output logic port_power_en,
  output logic port_reset_drive,
  output logic port_overcurrent_flag
);

  // one-hit decode shared by every command and field write
  function automatic logic wr_hit(input bus_req_t r, input logic [ADDR_W-1:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  function automatic logic rd_hit(input bus_req_t r, input logic [ADDR_W-1:0] ofs);
    return r.rd && (r.addr == ofs);
  endfunction

  // word returned for a read; unmapped and write-only offsets give zero
  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a, input state_t st);
    logic [DATA_W-1:0] w;
    w = '0;
    if (a == OFS_PORT_STATUS) begin
      w[BIT_PRESENT] = st.present_flag;
      w[BIT_ACTIVE] = st.active_flag;
      w[BIT_SLEEP] = st.sleep_flag;
      // [RL14] reported only per-port
      w[BIT_OVERCURRENT] = st.per_port_oc & st.oc_level;
      w[BIT_RESET] = (st.phase == RST_DRIVING);
      // [RL9] fixed power without switching
      w[BIT_POWER] = st.power_flag | st.no_switch;
      w[BIT_ATTACH_CHG] = st.attach_chg;
      w[BIT_RESET_CHG] = st.reset_chg;
    end else if (a == OFS_HUB_CTRL) begin
      w[BIT_SCHEME] = st.power_switch_scheme;
      w[BIT_NO_SWITCH] = st.no_switch;
      w[BIT_PER_PORT_OC] = st.per_port_oc;
      w[BIT_PORT_SELECT] = st.per_port_power_select;
    end
    return w;
  endfunction

  state_t state_reg;   // all registered state
  state_t state_next;  // its next value

  // command decode, visible to the checks below
  logic per_port_mode;
  logic single_on_cmd;
  logic single_power_off_cmd;
  logic all_power_on_cmd;
  logic all_power_off_cmd;
  logic reset_request_cmd;
  logic power_on_ok;
  logic power_off_ok;

  // command decode
  always_comb begin
    per_port_mode = state_reg.power_switch_scheme & state_reg.per_port_power_select;
    // [RL8] only a written 1 commands
    single_on_cmd = wr_hit(bus_req, OFS_PORT_STATUS) & bus_req.wdata[BIT_POWER];
    // [RL17] power-off command bit
    single_power_off_cmd = wr_hit(bus_req, OFS_PORT_STATUS) & bus_req.wdata[BIT_POWER_OFF];
    all_power_on_cmd = wr_hit(bus_req, OFS_HUB_CMD) & bus_req.wdata[BIT_ALL_ON];
    all_power_off_cmd = wr_hit(bus_req, OFS_HUB_CMD) & bus_req.wdata[BIT_ALL_OFF];
    // [RL13] only a written 1 requests reset
    reset_request_cmd = wr_hit(bus_req, OFS_PORT_STATUS) & bus_req.wdata[BIT_RESET];
    // [RL3] [RL4] [RL5] scheme picks the command pair
    power_on_ok = per_port_mode ? single_on_cmd : all_power_on_cmd;
    power_off_ok = per_port_mode ? single_power_off_cmd : all_power_off_cmd;
  end

  // next-state logic; everything holds while ce is low
  always_comb begin
    state_next = state_reg;
    if (ce) begin
      // [RL18] three-stage pin synchronisers
      state_next.oc_sync = {state_reg.oc_sync[SYNC_W-2:0], overcurrent_pin};
      state_next.att_sync = {state_reg.att_sync[SYNC_W-2:0], attach_pin};
      // level moves only once stages two and three agree
      if (state_reg.oc_sync[SYNC_W-2] == state_reg.oc_sync[SYNC_W-1]) begin
        state_next.oc_level = state_reg.oc_sync[SYNC_W-1];
      end
      if (state_reg.att_sync[SYNC_W-2] == state_reg.att_sync[SYNC_W-1]) begin
        state_next.att_level = state_reg.att_sync[SYNC_W-1];
      end

      // hub control register write
      if (wr_hit(bus_req, OFS_HUB_CTRL)) begin
        state_next.power_switch_scheme = bus_req.wdata[BIT_SCHEME];
        state_next.no_switch = bus_req.wdata[BIT_NO_SWITCH];
        state_next.per_port_oc = bus_req.wdata[BIT_PER_PORT_OC];
        state_next.per_port_power_select = bus_req.wdata[BIT_PORT_SELECT];
      end

      // [RL8] power on command
      if (power_on_ok) begin
        state_next.power_flag = 1'b1;
      end
      // [RL2] power off command
      if (power_off_ok) begin
        state_next.power_flag = 1'b0;
      end
      // [RL1] overcurrent wins over any on command
      if (state_reg.oc_level) begin
        state_next.power_flag = 1'b0;
      end

      // write-one-to-clear of the change flags, before any set below
      if (wr_hit(bus_req, OFS_PORT_STATUS)) begin
        if (bus_req.wdata[BIT_ATTACH_CHG]) begin
          state_next.attach_chg = 1'b0;
        end
        if (bus_req.wdata[BIT_RESET_CHG]) begin
          state_next.reset_chg = 1'b0;
        end
        // enable is set here on a present port and again at reset end; suspend is only set here, on an enabled port
        if (bus_req.wdata[BIT_ACTIVE] && state_reg.present_flag) begin
          state_next.active_flag = 1'b1;
        end
        if (bus_req.wdata[BIT_SLEEP] && state_reg.active_flag) begin
          state_next.sleep_flag = 1'b1;
        end
      end

      // attach state follows the pin, masked while unpowered so a lagging
      // synchroniser cannot keep raising the change flag against a clear
      state_next.present_flag = state_reg.att_level & (state_next.power_flag | state_next.no_switch);
      if (state_next.present_flag != state_reg.present_flag) begin
        state_next.attach_chg = 1'b1;
      end
      if (!state_reg.att_level) begin
        state_next.active_flag = 1'b0;
        state_next.sleep_flag = 1'b0;
      end

      // port reset sequencer
      case (state_reg.phase)
        RST_IDLE: begin
          if (reset_request_cmd) begin
            if (state_reg.present_flag) begin
              // [RL10] start reset signalling
              state_next.phase = RST_DRIVING;
              state_next.count = CNT_W'(RESET_CYCLES - 1);
            end else begin
              // [RL12] absent port: flag attach change
              state_next.attach_chg = 1'b1;
            end
          end
        end
        RST_DRIVING: begin
          if (state_reg.count == '0) begin
            // [RL11] flag drops with change set
            state_next.phase = RST_IDLE;
            state_next.reset_chg = 1'b1;
            state_next.active_flag = state_reg.present_flag;
            state_next.sleep_flag = 1'b0;
          end else begin
            state_next.count = state_reg.count - 1'b1;
          end
        end
        default: begin
          state_next.phase = RST_IDLE;
        end
      endcase

      // [RL6] unpowered port keeps no link state
      if (!(state_next.power_flag | state_next.no_switch)) begin
        state_next.present_flag = 1'b0;
        state_next.active_flag = 1'b0;
        state_next.sleep_flag = 1'b0;
        state_next.phase = RST_IDLE;
      end

      // [RL7] [RL19] read data stands for one cycle only
      state_next.rdata = bus_req.rd ? read_word(bus_req.addr, state_reg) : '0;
    end
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.phase <= RST_IDLE;
      {state_reg.power_switch_scheme, state_reg.no_switch, state_reg.per_port_oc,
       state_reg.per_port_power_select} <= CTRL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from state
  assign rdata = state_reg.rdata;
  assign port_power_en = state_reg.power_flag | state_reg.no_switch;
  assign port_reset_drive = (state_reg.phase == RST_DRIVING);
  // [RL15] [RL16] per-port overcurrent report
  assign port_overcurrent_flag = state_reg.per_port_oc & state_reg.oc_level;

  // checks
  default clocking chk_clk @(posedge clock);
  endclocking
  default disable iff (rst);

  // a power loss in the same cycle aborts the reset, so it is left out
  sequence reset_accepted;
    ce && reset_request_cmd && state_reg.present_flag && (state_reg.phase == RST_IDLE)
      && !state_reg.oc_level && !power_off_ok;
  endsequence

  sequence reset_finishing;
    ce && (state_reg.phase == RST_DRIVING) && (state_reg.count == '0);
  endsequence

  // [RL1] overcurrent drops power
  chk_oc_power_drop: assert property (ce && state_reg.oc_level |=> !state_reg.power_flag) // RL1
    else $error("overcurrent did not clear power flag");
  // [RL2] off command acts
  chk_off_cmd_clears: assert property (ce && power_off_ok |=> !state_reg.power_flag) // RL2
    else $error("power off command ignored");
  // [RL3] global scheme only
  chk_global_only: assert property (ce && !state_reg.power_switch_scheme && single_on_cmd // RL3
      && !all_power_on_cmd && !state_reg.power_flag |=> !state_reg.power_flag)
    else $error("single command acted in global scheme");
  // [RL4] mask blocks global
  chk_mask_blocks_global: assert property (ce && per_port_mode && all_power_on_cmd && !single_on_cmd // RL4
      && !state_reg.power_flag |=> !state_reg.power_flag)
    else $error("global command acted on selected port");
  // [RL8] single on acts
  chk_single_on_acts: assert property (ce && per_port_mode && single_on_cmd // RL8
      && !single_power_off_cmd && !state_reg.oc_level |=> state_reg.power_flag)
    else $error("single power on ignored on selected port");
  // [RL5] unselected takes global
  chk_unselected_global: assert property (ce && state_reg.power_switch_scheme // RL5
      && !state_reg.per_port_power_select && all_power_on_cmd && !all_power_off_cmd
      && !state_reg.oc_level |=> state_reg.power_flag)
    else $error("global on ignored for unselected port");
  // [RL6] unpowered port idle
  chk_unpowered_idle: assert property (!(state_reg.power_flag | state_reg.no_switch) // RL6
      |-> !state_reg.present_flag && !state_reg.active_flag && !state_reg.sleep_flag && !port_reset_drive)
    else $error("unpowered port holds link state");
  // [RL7] power flag readback
  chk_power_readback: assert property (ce && rd_hit(bus_req, OFS_PORT_STATUS) // RL7
      |=> rdata[BIT_POWER] == $past(port_power_en))
    else $error("power flag read mismatch");
  // [RL9] fixed power reads one
  chk_fixed_power_read: assert property (ce && state_reg.no_switch && rd_hit(bus_req, OFS_PORT_STATUS) // RL9
      |=> rdata[BIT_POWER])
    else $error("power flag not fixed without switching");
  // [RL10] reset starts full length
  chk_reset_start: assert property (reset_accepted // RL10
      |=> port_reset_drive && state_reg.count == CNT_W'(RESET_CYCLES - 1))
    else $error("reset request did not start signalling");
  // [RL11] reset end flagged
  chk_reset_finish: assert property (reset_finishing |=> !port_reset_drive && state_reg.reset_chg) // RL11
    else $error("reset end without change flag");
  // [RL12] absent port refused
  chk_reset_refused: assert property (ce && reset_request_cmd && !state_reg.present_flag // RL12
      && (state_reg.phase == RST_IDLE) |=> !port_reset_drive && state_reg.attach_chg)
    else $error("reset of absent port mishandled");
  // [RL13] zero requests nothing
  chk_zero_no_reset: assert property (ce && wr_hit(bus_req, OFS_PORT_STATUS) && !bus_req.wdata[BIT_RESET] // RL13
      && (state_reg.phase == RST_IDLE) |=> !port_reset_drive)
    else $error("written zero started a port reset");
  // [RL15] hidden overcurrent reads zero
  chk_oc_hidden_read: assert property (ce && !state_reg.per_port_oc && rd_hit(bus_req, OFS_PORT_STATUS) // RL15
      |=> !rdata[BIT_OVERCURRENT])
    else $error("overcurrent shown without per-port reporting");
  // [RL16] overcurrent bit readback
  chk_oc_report_read: assert property (ce && rd_hit(bus_req, OFS_PORT_STATUS) // RL16
      |=> rdata[BIT_OVERCURRENT] == $past(state_reg.per_port_oc && state_reg.oc_level))
    else $error("overcurrent read mismatch");
  // [RL18] synchronised pin settles
  chk_oc_sync_level: assert property ((ce && overcurrent_pin) [*4] |=> state_reg.oc_level) // RL18
    else $error("steady overcurrent pin not seen");
  // [RL19] reserved bits zero
  chk_reserved_zero: assert property (ce && rd_hit(bus_req, OFS_PORT_STATUS) |=> rdata[7:5] == 3'h0) // RL19
    else $error("reserved bits read nonzero");

endmodule // root_port_ctl
`default_nettype wire

// ==== tb/usb_device_model.sv ====
// far-side model: a downstream device plugged into the root port
// assumes the bench steers the plug state and a supply fault directly
`default_nettype none
module usb_device_model (
  input wire logic clock,
  input wire logic plugged,
  input wire logic fault,
  input wire logic port_power_en,
  input wire logic port_reset_drive,
  output logic attach_pin,
  output logic overcurrent_pin,
  output logic [7:0] reset_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drive_d = 1'b0; // last reset drive level
  logic [7:0] count_q = 8'h00; // finished reset pulses so far

  // a device only shows attach while its supply is up
  assign attach_pin = plugged & port_power_en;
  // supply fault is seen by the switch whatever the power state
  assign overcurrent_pin = fault;

  // count finished reset pulses, so a truncated pulse is not missed
  assign reset_count = count_q;
  always @(posedge clock) begin
    if (drive_d && !port_reset_drive) begin
      count_q <= count_q + 8'h01;
    end
    drive_d <= port_reset_drive;
  end
endmodule // usb_device_model
`default_nettype wire

// ==== tb/root_port_ctl_tb.sv ====
// self-checking bench for the root port power, reset and overcurrent block
// assumes the strobe register port of the package and a short reset length
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end
module root_port_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import port_ctl_pkg::*;
  localparam int unsigned RESET_P = 8; // short reset so the run stays brief
  logic clock, rst, ce, plugged, fault;
  bus_req_t req; // register port request
  logic [DATA_W-1:0] rdata, v;
  logic port_power_en, port_reset_drive, port_overcurrent_flag, attach_pin, overcurrent_pin;
  logic [7:0] reset_count; // finished resets seen by the device
  int n_fail, total_checks, i;

  root_port_ctl #(.RESET_CYCLES(RESET_P)) uut (.clock(clock), .rst(rst), .ce(ce), .bus_req(req),
    .rdata(rdata), .overcurrent_pin(overcurrent_pin), .attach_pin(attach_pin),
    .port_power_en(port_power_en), .port_reset_drive(port_reset_drive),
    .port_overcurrent_flag(port_overcurrent_flag));
  usb_device_model dev (.clock(clock), .plugged(plugged), .fault(fault), .port_power_en(port_power_en),
    .port_reset_drive(port_reset_drive), .attach_pin(attach_pin), .overcurrent_pin(overcurrent_pin),
    .reset_count(reset_count));

  // 25 MHz clock
  initial clock = 1'b0;
  always #20 clock = ~clock;

  // one-cycle write strobe
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle only
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // one power command, then the flag and the switch drive
  task automatic pw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic e);
    wr_reg(a, d);
    rd_reg(OFS_PORT_STATUS, v);
    `CHK(v[BIT_POWER], e)
    `CHK(port_power_en, e)
  endtask

  // counts, then verdict; the only place the run ends
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog, well above the two hundred or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    print_verdict();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    req = '0;
    plugged = 1'b1;
    fault = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd_reg(OFS_HUB_CTRL, v);
    `CHK(v, 32'h0000_0000)
    rd_reg(OFS_PORT_STATUS, v);
    `CHK(v[BIT_POWER], 1'b0)
    // global scheme
    pw(OFS_PORT_STATUS, 32'h0000_0100, 1'b0);
    pw(OFS_HUB_CMD, 32'h0001_0000, 1'b1);
    pw(OFS_PORT_STATUS, 32'h0000_0200, 1'b1);
    pw(OFS_PORT_STATUS, 32'h0000_0000, 1'b1);
    rd_reg(OFS_PORT_STATUS, v);
    `CHK(v[7:5], 3'h0)
    pw(OFS_HUB_CMD, 32'h0000_0001, 1'b0);
    // per-port scheme, this port selected
    wr_reg(OFS_HUB_CTRL, 32'h0000_0009);
    pw(OFS_HUB_CMD, 32'h0001_0000, 1'b0);
    pw(OFS_PORT_STATUS, 32'h0000_0100, 1'b1);
    pw(OFS_PORT_STATUS, 32'h0000_0000, 1'b1);
    pw(OFS_HUB_CMD, 32'h0000_0001, 1'b1);
    pw(OFS_PORT_STATUS, 32'h0000_0200, 1'b0);
    pw(OFS_PORT_STATUS, 32'h0000_0000, 1'b0);
    // per-port scheme, this port not selected
    wr_reg(OFS_HUB_CTRL, 32'h0000_0001);
    pw(OFS_PORT_STATUS, 32'h0000_0100, 1'b0);
    pw(OFS_HUB_CMD, 32'h0001_0000, 1'b1);
    pw(OFS_PORT_STATUS, 32'h0000_0200, 1'b1);
    // port reset on a present device
    repeat (8) @(posedge clock);
    wr_reg(OFS_PORT_STATUS, 32'h0000_0000);
    #1;
    `CHK(port_reset_drive, 1'b0)
    wr_reg(OFS_PORT_STATUS, 32'h0000_0010);
    #1;
    `CHK(port_reset_drive, 1'b1)
    rd_reg(OFS_PORT_STATUS, v);
    `CHK(v[BIT_RESET], 1'b1)
    // drive stands RESET_P cycles from the request edge; the read used two
    for (i = 0; i < 40 && port_reset_drive === 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    `CHK(i, RESET_P - 2)
    rd_reg(OFS_PORT_STATUS, v);
    `CHK({v[BIT_RESET], v[BIT_RESET_CHG]}, 2'b01)
    `CHK(reset_count, 8'h01)
    wr_reg(OFS_PORT_STATUS, 32'h0010_0000);
    // power lost in mid-reset
    wr_reg(OFS_PORT_STATUS, 32'h0000_0010);
    wr_reg(OFS_HUB_CMD, 32'h0000_0001);
    repeat (8) @(posedge clock);
    rd_reg(OFS_PORT_STATUS, v);
    `CHK(v[4:0], 5'h00)
    `CHK(port_reset_drive, 1'b0)
    // reset request on an absent port
    wr_reg(OFS_PORT_STATUS, 32'h0001_0000);
    wr_reg(OFS_PORT_STATUS, 32'h0000_0010);
    rd_reg(OFS_PORT_STATUS, v);
    `CHK({v[BIT_RESET], v[BIT_ATTACH_CHG]}, 2'b01)
    `CHK(port_reset_drive, 1'b0)
    // overcurrent with per-port reporting
    wr_reg(OFS_HUB_CTRL, 32'h0000_0004);
    wr_reg(OFS_HUB_CMD, 32'h0001_0000);
    fault <= 1'b1;
    @(posedge clock);
    #1;
    `CHK(port_overcurrent_flag, 1'b0)
    repeat (8) @(posedge clock);
    `CHK(port_overcurrent_flag, 1'b1)
    rd_reg(OFS_PORT_STATUS, v);
    `CHK({v[BIT_OVERCURRENT], v[BIT_POWER]}, 2'b10)
    fault <= 1'b0;
    repeat (8) @(posedge clock);
    `CHK(port_overcurrent_flag, 1'b0)
    rd_reg(OFS_PORT_STATUS, v);
    `CHK(v[BIT_OVERCURRENT], 1'b0)
    // overcurrent without per-port reporting
    wr_reg(OFS_HUB_CTRL, 32'h0000_0000);
    wr_reg(OFS_HUB_CMD, 32'h0001_0000);
    fault <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK(port_overcurrent_flag, 1'b0)
    rd_reg(OFS_PORT_STATUS, v);
    `CHK({v[BIT_OVERCURRENT], v[BIT_POWER]}, 2'b00)
    fault <= 1'b0;
    // no power switching
    wr_reg(OFS_HUB_CTRL, 32'h0000_0002);
    pw(OFS_HUB_CMD, 32'h0000_0001, 1'b1);
    // a command strobed while ce is low is lost
    wr_reg(OFS_HUB_CTRL, 32'h0000_0000);
    ce <= 1'b0;
    wr_reg(OFS_HUB_CMD, 32'h0001_0000);
    ce <= 1'b1;
    rd_reg(OFS_PORT_STATUS, v);
    `CHK(v[BIT_POWER], 1'b0)
    pw(OFS_HUB_CMD, 32'h0001_0000, 1'b1);
    // unmapped and write-only places read zero
    rd_reg(4'hc, v);
    `CHK(v, 32'h0000_0000)
    rd_reg(OFS_HUB_CMD, v);
    `CHK(v, 32'h0000_0000)
    print_verdict();
  end
endmodule // root_port_ctl_tb
`default_nettype wire
